// File: hw/pg_fall_pkg.sv
package pg_fall_pkg;
	// Register byte addresses on the AXI4-Lite bus (index times four)
	localparam logic [7:0] FLAGS_INDEX = 8'h3D;
	localparam logic [7:0] MASK_INDEX = 8'h3E;
	localparam logic [9:0] FLAGS_ADDR = {FLAGS_INDEX, 2'b00};
	localparam logic [9:0] MASK_ADDR = {MASK_INDEX, 2'b00};
	localparam int ADDR_W = 10;
	// Field layout: bits 7..4 linear regulators 4..1, bits 3..0 converters 4..1
	localparam int LDO_LSB = 4;
	localparam int BUCK_LSB = 0;
	localparam int FLAG_W = 8;
	// Reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'hFF;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hw/pg_fall_flags.sv
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module pg_fall_flags (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Regulator status, index 0 is regulator 1
	input wire logic [3:0] ldo_good_i,
	input wire logic [3:0] ldo_en_i,
	input wire logic [3:0] buck_good_i,
	input wire logic [3:0] buck_en_i,
	// AXI4-Lite write address and data
	input wire logic [31:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	// AXI4-Lite write response
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	// AXI4-Lite read
	input wire logic [31:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	// Interrupt, level
	output logic irq_o
);
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} wr_state_t;

	// Word offset of a byte address
	function automatic logic [9:0] word_addr(input logic [31:0] a);
		return {a[9:2], 2'b00};
	endfunction

	logic [7:0] flags, next_flags;
	logic [7:0] mask, next_mask;
	logic [3:0] ldo_good_q, next_ldo_good_q;
	logic [3:0] buck_good_q, next_buck_good_q;
	logic [31:0] aw_q, next_aw_q;
	logic [31:0] w_q, next_w_q;
	logic [3:0] ws_q, next_ws_q;
	logic aw_have, next_aw_have;
	logic w_have, next_w_have;
	wr_state_t wr_state, next_wr_state;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;
	logic [7:0] events;
	logic [7:0] clear_bits;
	logic do_write;

	// Qualified falling edges; disabled regulators cannot raise a flag
	always_comb begin
		next_ldo_good_q = ldo_good_i;
		next_buck_good_q = buck_good_i;
		events = '0;
		events[pg_fall_pkg::LDO_LSB +: 4] = ldo_good_q & ~ldo_good_i & ldo_en_i;
		events[pg_fall_pkg::BUCK_LSB +: 4] = buck_good_q & ~buck_good_i & buck_en_i;
	end

	// Write channel capture; address and data accepted in either order
	always_comb begin
		next_aw_q = aw_q;
		next_w_q = w_q;
		next_ws_q = ws_q;
		next_aw_have = aw_have;
		next_w_have = w_have;
		next_wr_state = wr_state;
		next_bresp = bresp;
		do_write = 1'b0;
		if (awvalid_i && awready_o) begin
			next_aw_q = awaddr_i;
			next_aw_have = 1'b1;
		end
		if (wvalid_i && wready_o) begin
			next_w_q = wdata_i;
			next_ws_q = wstrb_i;
			next_w_have = 1'b1;
		end
		case (wr_state)
			WR_IDLE: begin
				if (aw_have && w_have) begin
					do_write = 1'b1;
					next_aw_have = 1'b0;
					next_w_have = 1'b0;
					next_wr_state = WR_RESP;
					if (word_addr(aw_q) == pg_fall_pkg::FLAGS_ADDR || word_addr(aw_q) == pg_fall_pkg::MASK_ADDR)
						next_bresp = pg_fall_pkg::RESP_OKAY;
					else
						next_bresp = pg_fall_pkg::RESP_SLVERR;
				end
			end
			WR_RESP: begin
				if (bready_i)
					next_wr_state = WR_IDLE;
			end
			default: next_wr_state = WR_IDLE;
		endcase
	end

	// Register updates; byte lane 0 carries the 8-bit fields
	always_comb begin
		clear_bits = '0;
		next_mask = mask;
		if (do_write && ws_q[0]) begin
			if (word_addr(aw_q) == pg_fall_pkg::FLAGS_ADDR)
				clear_bits = w_q[7:0];
			if (word_addr(aw_q) == pg_fall_pkg::MASK_ADDR)
				next_mask = w_q[7:0];
		end
		// A fresh event outranks a clear in the same cycle, so nothing is lost
		next_flags = (flags & ~clear_bits) | events;
	end

	// Read channel; one read in flight, answered one cycle after address
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && rready_i)
			next_rvalid = 1'b0;
		if (arvalid_i && arready_o) begin
			next_rvalid = 1'b1;
			next_rresp = pg_fall_pkg::RESP_OKAY;
			next_rdata = 32'h0000_0000;
			if (word_addr(araddr_i) == pg_fall_pkg::FLAGS_ADDR)
				next_rdata = {24'h00_0000, flags};
			else if (word_addr(araddr_i) == pg_fall_pkg::MASK_ADDR)
				next_rdata = {24'h00_0000, mask};
			else
				next_rresp = pg_fall_pkg::RESP_SLVERR;
		end
	end

	// All state registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flags <= pg_fall_pkg::FLAGS_RESET;
			mask <= pg_fall_pkg::MASK_RESET;
			ldo_good_q <= 4'h0;
			buck_good_q <= 4'h0;
			aw_q <= 32'h0000_0000;
			w_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			wr_state <= WR_IDLE;
			bresp <= pg_fall_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= pg_fall_pkg::RESP_OKAY;
		end else begin
			flags <= next_flags;
			mask <= next_mask;
			ldo_good_q <= next_ldo_good_q;
			buck_good_q <= next_buck_good_q;
			aw_q <= next_aw_q;
			w_q <= next_w_q;
			ws_q <= next_ws_q;
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			wr_state <= next_wr_state;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// Outputs; the good inputs reset low, so a regulator already down at release raises nothing
	assign awready_o = !aw_have && wr_state == WR_IDLE;
	assign wready_o = !w_have && wr_state == WR_IDLE;
	assign bvalid_o = wr_state == WR_RESP;
	assign bresp_o = bresp;
	assign arready_o = !rvalid;
	assign rvalid_o = rvalid;
	assign rdata_o = rdata;
	assign rresp_o = rresp;
	assign irq_o = |(flags & ~mask);

	// Checks
	a_ldo_edge_sets: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$past(arst_n_i) && $fell(ldo_good_i[0]) && ldo_en_i[0] |=> flags[4]) else $error("ldo1 edge lost");
	a_buck_edge_sets: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$past(arst_n_i) && $fell(buck_good_i[3]) && buck_en_i[3] |=> flags[3]) else $error("buck4 edge lost");
	a_ldo_disabled_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!ldo_en_i[1] && !flags[5] |=> !flags[5]) else $error("ldo2 flag set while off");
	a_buck_disabled_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!buck_en_i[0] && !flags[0] |=> !flags[0]) else $error("buck1 flag set while off");
	a_clear_by_one: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		do_write && ws_q[0] && word_addr(aw_q) == pg_fall_pkg::FLAGS_ADDR && w_q[1] && events[1] == 1'b0
		|=> !flags[1]) else $error("flag not cleared");
	a_zero_no_edge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!$past(flags[6]) && flags[6] |-> $past(events[6])) else $error("flag rose without edge");
	a_flags_reg_addr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		arvalid_i && arready_o && word_addr(araddr_i) == pg_fall_pkg::FLAGS_ADDR
		|=> rvalid_o && rdata_o[7:0] == $past(flags)) else $error("bad flags read");
	a_irq_masking: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		flags[2] && !mask[2] |-> irq_o) else $error("unmasked flag gave no irq");
	a_sticky_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		flags[7] && !(do_write && word_addr(aw_q) == pg_fall_pkg::FLAGS_ADDR) |=> flags[7])
		else $error("flag dropped");
	c_irq_seen: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(irq_o));
	c_write_done: cover property (@(posedge clk_i) disable iff (!arst_n_i) bvalid_o && bready_i);
	c_set_and_clear: cover property (@(posedge clk_i) disable iff (!arst_n_i) |(clear_bits & events));
endmodule

// File: dv/pg_fall_flags_bench.sv
`timescale 1ns/100ps
module power_good_fall_flag_register_bench;
	localparam logic [31:0] flag_a = 32'(pg_fall_pkg::FLAGS_ADDR);
	localparam logic [31:0] mask_a = 32'(pg_fall_pkg::MASK_ADDR);
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [3:0] ldo_good_i = 4'h0, ldo_en_i = 4'h0, buck_good_i = 4'h0, buck_en_i = 4'h0;
	logic [31:0] awaddr_i = 32'h0, wdata_i = 32'h0, araddr_i = 32'h0, rdata_o, v;
	logic [3:0] wstrb_i = 4'hF;
	logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
	logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
	logic [1:0] bresp_o, rresp_o, r;
	logic [7:0] g, exp_f;
	int errors = 0, checks_done = 0;

	pg_fall_flags dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ldo_good_i(ldo_good_i), .ldo_en_i(ldo_en_i),
		.buck_good_i(buck_good_i), .buck_en_i(buck_en_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
		.awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
		.bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i),
		.arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
		.rvalid_o(rvalid_o), .rready_i(rready_i), .irq_o(irq_o));

	// 100 MHz clock
	always #5 clk_i = ~clk_i;

	task automatic complete_run();
		if (errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, s, e);
		end
	endtask

	// A hung handshake counts as a mismatch and ends the run
	task automatic bound(input int n);
		if (n >= 50) begin
			errors++;
			$display("MISMATCH at %0t: bus handshake timed out", $time);
			complete_run();
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] rs);
		int n;
		logic aw, w;
		n = 0;
		aw = 1'b1;
		w = 1'b1;
		awaddr_i <= a;
		wdata_i <= {24'h000000, d};
		awvalid_i <= 1'b1;
		wvalid_i <= 1'b1;
		bready_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (aw && awready_o === 1'b1) begin
				aw = 1'b0;
				awvalid_i <= 1'b0;
			end
			if (w && wready_o === 1'b1) begin
				w = 1'b0;
				wvalid_i <= 1'b0;
			end
		end while (bvalid_o !== 1'b1 && n < 50);
		rs = bresp_o;
		bready_i <= 1'b0;
		bound(n);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
		int n;
		n = 0;
		araddr_i <= a;
		arvalid_i <= 1'b1;
		rready_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (arready_o === 1'b1) begin
				arvalid_i <= 1'b0;
			end
		end while (rvalid_o !== 1'b1 && n < 50);
		d = rdata_o;
		rs = rresp_o;
		rready_i <= 1'b0;
		bound(n);
	endtask

	// Drive the regulator lines, then let two samples land
	task automatic pins(input logic [7:0] good, input logic [7:0] en);
		{ldo_good_i, buck_good_i} <= good;
		{ldo_en_i, buck_en_i} <= en;
		repeat (2) @(posedge clk_i);
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		rd(flag_a, v, r);
		chk(v, 32'h0);
		rd(mask_a, v, r);
		chk(v, 32'hFF);
		// Drop one line at a time; each fall adds exactly its own bit
		g = 8'hFF;
		exp_f = 8'h00;
		pins(g, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			g[i] = 1'b0;
			pins(g, 8'hFF);
			exp_f[i] = 1'b1;
			rd(flag_a, v, r);
			chk(v, {24'h0, exp_f});
		end
		chk({31'h0, irq_o}, 32'h0);
		wr(mask_a, 8'hEF, r);
		chk({31'h0, irq_o}, 32'h1);
		wr(flag_a, 8'h00, r);
		rd(flag_a, v, r);
		chk(v, 32'hFF);
		chk({31'h0, irq_o}, 32'h1);
		wr(flag_a, 8'h10, r);
		chk({30'h0, r}, {30'h0, pg_fall_pkg::RESP_OKAY});
		rd(flag_a, v, r);
		chk(v, 32'hEF);
		// Only the cleared bit was unmasked, so the request drops with it
		chk({31'h0, irq_o}, 32'h0);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		// All bits cleared first, so a fall while switched off shows on any bit
		wr(flag_a, 8'hFF, r);
		pins(8'hFF, 8'h00);
		pins(8'h00, 8'h00);
		rd(flag_a, v, r);
		chk(v, 32'h00);
		// Enabled again, one regulator of each kind sets its bit anew
		pins(8'hFF, 8'hFF);
		pins(8'hEE, 8'hFF);
		rd(flag_a, v, r);
		chk(v, 32'h11);
		chk({31'h0, irq_o}, 32'h1);
		// A fall sampled on the very edge that clears its bit must keep the bit
		pins(8'hFF, 8'hFF);
		fork
			wr(flag_a, 8'h01, r);
			begin
				@(posedge clk_i);
				buck_good_i[0] <= 1'b0;
			end
		join
		rd(flag_a, v, r);
		chk(v, 32'h11);
		// Only converter three unmasked: quiet until its own fall
		wr(mask_a, 8'hFB, r);
		chk({31'h0, irq_o}, 32'h0);
		pins(8'hFA, 8'hFF);
		chk({31'h0, irq_o}, 32'h1);
		rd(flag_a, v, r);
		chk(v, 32'h15);
		// Unmapped place: error answer, reads zero, flags untouched
		wr(32'h0, 8'hFF, r);
		chk({30'h0, r}, {30'h0, pg_fall_pkg::RESP_SLVERR});
		rd(32'h0, v, r);
		chk({30'h0, r}, {30'h0, pg_fall_pkg::RESP_SLVERR});
		chk(v, 32'h0);
		rd(flag_a, v, r);
		chk(v, 32'h15);
		// Reset in mid-run brings both registers back to their reset values
		arst_n_i <= 1'b0;
		@(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		rd(flag_a, v, r);
		chk(v, 32'h0);
		rd(mask_a, v, r);
		chk(v, 32'hFF);
		complete_run();
	end
endmodule
